// >>> thermal_alarm_status_mask.sv
module thermal_alarm_status_mask
    import thermal_alarm_pkg::*;
#(
    parameter int TEMP_W       = 8,
    parameter int LSB_PER_DEGC = 1
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     resetn_i,
    input  wire logic [NUM_CH-1:0]        conv_done_i,
    input  wire logic [NUM_CH*TEMP_W-1:0] temp_i,
    input  wire logic [NUM_CH*TEMP_W-1:0] high_limit_i,
    input  wire logic [NUM_CH*TEMP_W-1:0] low_limit_i,
    input  wire logic [NUM_CH*TEMP_W-1:0] ot_limit_i,
    input  wire logic [NUM_CH-1:0]        ot_limit_wr_i,
    input  wire logic [NUM_CH-1:0]        sensor_fault_i,
    input  wire logic [ADDR_W-1:0]        reg_addr_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [REG_W-1:0]         reg_wdata_i,
    input  wire logic                     alert_resp_done_i,
    output logic      [REG_W-1:0]         reg_rdata_o,
    output logic                          alert_n_o,
    output logic                          alert_oe_o,
    output logic                          overt_n_o,
    output logic                          overt_oe_o
);

    localparam int HYST_LSB = HYST_DEGC * LSB_PER_DEGC;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (TEMP_W < 2 || TEMP_W > 16) begin : g_bad_width
        $error("TEMP_W must lie between 2 and 16");
    end
    if (LSB_PER_DEGC < 1 || HYST_LSB >= (1 << TEMP_W)) begin : g_bad_scale
        $error("LSB_PER_DEGC does not fit TEMP_W");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [REG_W-1:0] alert_mask;
    logic [REG_W-1:0] ot_mask;
    logic [REG_W-1:0] high_flags;
    logic [REG_W-1:0] low_flags;
    logic [REG_W-1:0] ot_flags;
    logic [REG_W-1:0] fault_flags;
    logic             alert_latch;
    logic [REG_W-1:0] next_alert_mask;
    logic [REG_W-1:0] next_ot_mask;
    logic [REG_W-1:0] next_high_flags;
    logic [REG_W-1:0] next_low_flags;
    logic [REG_W-1:0] next_ot_flags;
    logic [REG_W-1:0] next_fault_flags;
    logic             next_alert_latch;
    logic [REG_W-1:0] next_rdata;
    logic             next_overt;

    // Per-channel events in register bit layout
    logic [REG_W-1:0] high_set;
    logic [REG_W-1:0] low_set;
    logic [REG_W-1:0] ot_set;
    logic [REG_W-1:0] ot_clr;
    logic [REG_W-1:0] fault_upd;
    logic [REG_W-1:0] fault_val;

    // Bus and alert events
    logic             rd_high;
    logic             rd_low;
    logic             alert_clear;
    logic             alert_set;

    ////////////////////////////////////////////////////////////////////////////
    // Channel evaluation
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        localparam int AB = ALERT_BIT[c];
        localparam int OB = OT_BIT[c];
        logic hi_x;
        logic lo_x;
        logic ot_x;
        logic ot_cool;
        logic ot_lim_clr;

        channel_judge #(
            .TEMP_W   (TEMP_W),
            .HYST_LSB (HYST_LSB)
        ) u_judge (
            .temp_i           (temp_i[c*TEMP_W +: TEMP_W]),
            .high_limit_i     (high_limit_i[c*TEMP_W +: TEMP_W]),
            .low_limit_i      (low_limit_i[c*TEMP_W +: TEMP_W]),
            .ot_limit_i       (ot_limit_i[c*TEMP_W +: TEMP_W]),
            .high_exceed_o    (hi_x),
            .low_below_o      (lo_x),
            .ot_exceed_o      (ot_x),
            .ot_cooled_o      (ot_cool),
            .ot_limit_clear_o (ot_lim_clr)
        );

        // Set only at this channel's conversion end, masked or not
        assign high_set[AB] = conv_done_i[c] & hi_x;
        assign low_set[AB]  = conv_done_i[c] & lo_x;
        assign ot_set[OB]   = conv_done_i[c] & ot_x;
        // Hysteresis release or a limit raised far enough
        assign ot_clr[OB]   = (conv_done_i[c] & ot_cool)
                            | (ot_limit_wr_i[c] & ot_lim_clr);

        // Remote channels only; the local channel has no sensor pins
        if (c == LOCAL_CH) begin : g_local
            assign fault_upd[FAULT_BIT[c]] = 1'b0;
            assign fault_val[FAULT_BIT[c]] = 1'b0;
        end else begin : g_remote
            assign fault_upd[FAULT_BIT[c]] = conv_done_i[c];
            assign fault_val[FAULT_BIT[c]] = sensor_fault_i[c];

            // Each remote conversion replaces the fault bit
            chk_fault_replace: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
                conv_done_i[c] |=> fault_flags[FAULT_BIT[c]] == $past(sensor_fault_i[c]))
                else $error("fault flag not replaced");
        end

        // Checked against the raw comparison, not the judge outputs
        chk_low_flag_set: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
            conv_done_i[c] && temp_i[c*TEMP_W +: TEMP_W] < low_limit_i[c*TEMP_W +: TEMP_W]
            |=> low_flags[AB])
            else $error("low flag not set");

        chk_ot_hyst_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
            conv_done_i[c] && {1'b0, temp_i[c*TEMP_W +: TEMP_W]} + (TEMP_W+1)'(HYST_LSB)
                              < {1'b0, ot_limit_i[c*TEMP_W +: TEMP_W]}
            |=> !ot_flags[OB])
            else $error("overtemp flag kept below hysteresis");

        chk_ot_limit_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
            ot_limit_wr_i[c] && !conv_done_i[c]
            && {1'b0, ot_limit_i[c*TEMP_W +: TEMP_W]}
               >= {1'b0, temp_i[c*TEMP_W +: TEMP_W]} + (TEMP_W+1)'(HYST_LSB)
            |=> !ot_flags[OB])
            else $error("overtemp flag kept after limit raise");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag and mask next values
    always_comb begin
        rd_high     = reg_rd_i && (reg_addr_i == ADDR_HIGH_FLAGS);
        rd_low      = reg_rd_i && (reg_addr_i == ADDR_LOW_FLAGS);
        alert_clear = rd_high || alert_resp_done_i;
        // New set beats a clear in the same cycle
        next_high_flags = high_set | (high_flags & ~{REG_W{rd_high}});
        next_low_flags  = low_set | (low_flags & ~{REG_W{rd_low}});
        // Reading does not clear overtemperature flags
        next_ot_flags   = ot_set | (ot_flags & ~ot_clr);
        next_fault_flags = (fault_val & fault_upd) | (fault_flags & ~fault_upd);
        next_fault_flags[FAULT_RSVD] = 1'b0;
        next_alert_mask = alert_mask;
        next_ot_mask    = ot_mask;
        if (reg_wr_i && reg_addr_i == ADDR_ALERT_MASK) begin
            next_alert_mask = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == ADDR_OT_MASK) begin
            next_ot_mask = reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alert latch and overtemperature output next values
    always_comb begin
        // Conversion finding an unmasked high or low limit violation asserts the alert
        alert_set = |((high_set | low_set) & ~next_alert_mask);
        // Released by high-flag register read or alert response; also drops once no unmasked high or low flag remains
        next_alert_latch = alert_set
                         | (alert_latch & ~alert_clear
                            & |((next_high_flags | next_low_flags)
                                & ~next_alert_mask));
        next_overt = |(next_ot_flags & ~next_ot_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    always_comb begin
        unique case (reg_addr_i)
            ADDR_ALERT_MASK: next_rdata = alert_mask;
            ADDR_OT_MASK:    next_rdata = ot_mask;
            ADDR_HIGH_FLAGS: next_rdata = high_flags;
            ADDR_OT_FLAGS:   next_rdata = ot_flags;
            ADDR_FAULT:      next_rdata = fault_flags;
            ADDR_LOW_FLAGS:  next_rdata = low_flags;
            default:         next_rdata = READ_ZERO;
        endcase
        if (!reg_rd_i) begin
            next_rdata = reg_rdata_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alert_mask  <= MASK_RESET;
            ot_mask     <= MASK_RESET;
            high_flags  <= FLAGS_RESET;
            low_flags   <= FLAGS_RESET;
            ot_flags    <= FLAGS_RESET;
            fault_flags <= FLAGS_RESET;
            alert_latch <= 1'b0;
            alert_oe_o  <= 1'b0;
            alert_n_o   <= 1'b1;
            overt_oe_o  <= 1'b0;
            overt_n_o   <= 1'b1;
            reg_rdata_o <= READ_ZERO;
        end else begin
            alert_mask  <= next_alert_mask;
            ot_mask     <= next_ot_mask;
            high_flags  <= next_high_flags;
            low_flags   <= next_low_flags;
            ot_flags    <= next_ot_flags;
            fault_flags <= next_fault_flags;
            alert_latch <= next_alert_latch;
            alert_oe_o  <= next_alert_latch;
            alert_n_o   <= ~next_alert_latch;
            overt_oe_o  <= next_overt;
            overt_n_o   <= ~next_overt;
            reg_rdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence high_read_quiet;
        reg_rd_i && reg_addr_i == ADDR_HIGH_FLAGS && conv_done_i == '0;
    endsequence

    sequence alert_released;
        !alert_oe_o && alert_n_o;
    endsequence

    chk_high_read_clear: assert property (high_read_quiet |=> high_flags == '0)
        else $error("high flags not cleared by read");

    chk_alert_release: assert property (
        (alert_resp_done_i || rd_high) && !alert_set |=> alert_released)
        else $error("alert not released");

    chk_alert_reassert: assert property (
        alert_released ##1 (alert_set && !alert_clear) |=> alert_oe_o && !alert_n_o)
        else $error("alert not reasserted at conversion");

    chk_alert_unmasked: assert property (
        alert_oe_o |-> |((high_flags | low_flags) & ~alert_mask))
        else $error("alert without unmasked flag");

    chk_ot_sticky: assert property (
        conv_done_i == '0 && ot_limit_wr_i == '0 |=> ot_flags == $past(ot_flags))
        else $error("overtemp flag changed without cause");

    chk_overt_pin: assert property (
        overt_oe_o == |(ot_flags & ~ot_mask) && overt_n_o == !overt_oe_o)
        else $error("overtemp output mismatch");

    chk_ot_mask_write: assert property (
        reg_wr_i && reg_addr_i == ADDR_OT_MASK |=> ot_mask == $past(reg_wdata_i))
        else $error("overtemp mask not written");

    chk_alert_mask_write: assert property (
        reg_wr_i && reg_addr_i == ADDR_ALERT_MASK
        |=> alert_mask == $past(reg_wdata_i))
        else $error("alert mask not written");

    chk_fault_reserved: assert property (
        reg_rd_i && reg_addr_i == ADDR_FAULT |=> reg_rdata_o[FAULT_RSVD] == 1'b0)
        else $error("reserved fault bit read as one");

    chk_high_set_win: assert property (
        conv_done_i[LOCAL_CH] && temp_i[TEMP_W-1:0] > high_limit_i[TEMP_W-1:0]
        |=> high_flags[ALERT_BIT[LOCAL_CH]])
        else $error("local high flag not set");

    chk_ot_local_set: assert property (
        conv_done_i[LOCAL_CH] && temp_i[TEMP_W-1:0] > ot_limit_i[TEMP_W-1:0]
        |=> ot_flags[OT_BIT[LOCAL_CH]])
        else $error("local overtemp flag not set");

    chk_ot_read_keeps: assert property (
        reg_rd_i && reg_addr_i == ADDR_OT_FLAGS |=> reg_rdata_o == $past(ot_flags))
        else $error("overtemp read data wrong");

endmodule

// >>> thermal_alarm_pkg.sv
package thermal_alarm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Channel organisation: channel 0 is local, 1 to 7 are remote
    localparam int NUM_CH   = 8;
    localparam int LOCAL_CH = 0;
    localparam int REG_W    = 8;
    localparam int ADDR_W   = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the register port
    localparam logic [ADDR_W-1:0] ADDR_ALERT_MASK = 8'h42;
    localparam logic [ADDR_W-1:0] ADDR_OT_MASK    = 8'h43;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_FLAGS = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_OT_FLAGS   = 8'h45;
    localparam logic [ADDR_W-1:0] ADDR_FAULT      = 8'h46;
    localparam logic [ADDR_W-1:0] ADDR_LOW_FLAGS  = 8'h47;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and reserved fields
    localparam logic [REG_W-1:0] MASK_RESET  = 8'h00;
    localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [REG_W-1:0] READ_ZERO   = 8'h00;
    localparam int               FAULT_RSVD  = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Bit position of each channel, indexed by channel number
    localparam int ALERT_BIT [NUM_CH] = '{6, 0, 1, 2, 3, 4, 5, 7};
    localparam int OT_BIT    [NUM_CH] = '{7, 0, 1, 2, 3, 4, 5, 6};
    localparam int FAULT_BIT [NUM_CH] = '{7, 0, 1, 2, 3, 4, 5, 6};

    ////////////////////////////////////////////////////////////////////////////
    // Overtemperature hysteresis in degrees Celsius
    localparam int HYST_DEGC = 4;

endpackage

// >>> channel_judge.sv
module channel_judge #(
    parameter int TEMP_W   = 8,
    parameter int HYST_LSB = 4
) (
    input  wire logic [TEMP_W-1:0] temp_i,
    input  wire logic [TEMP_W-1:0] high_limit_i,
    input  wire logic [TEMP_W-1:0] low_limit_i,
    input  wire logic [TEMP_W-1:0] ot_limit_i,
    output logic                   high_exceed_o,
    output logic                   low_below_o,
    output logic                   ot_exceed_o,
    output logic                   ot_cooled_o,
    output logic                   ot_limit_clear_o
);

    // One extra bit so that adding the hysteresis cannot wrap
    logic [TEMP_W:0] temp_plus_hyst;

    // Limit comparisons of one channel
    always_comb begin
        temp_plus_hyst   = {1'b0, temp_i} + (TEMP_W+1)'(HYST_LSB);
        high_exceed_o    = temp_i > high_limit_i;
        low_below_o      = temp_i < low_limit_i;
        ot_exceed_o      = temp_i > ot_limit_i;
        ot_cooled_o      = temp_plus_hyst < {1'b0, ot_limit_i};
        ot_limit_clear_o = {1'b0, ot_limit_i} >= temp_plus_hyst;
    end

endmodule

// >>> smbus_host_model.sv
module smbus_host_model (
    input  wire logic       clk_i,
    output logic      [7:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o,
    output logic            resp_done_o
);
    timeunit 1ns;
    timeprecision 1ps;

    //////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        addr_o      = 8'h00;
        wr_o        = 1'b0;
        rd_o        = 1'b0;
        wdata_o     = 8'h00;
        resp_done_o = 1'b0;
    end

    // One byte transfer; released address and data show the inverse, never the old value
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= w;
        rd_o    <= !w;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask

    // Completed alert-response transaction, arbitration already won
    task automatic alert_resp();
        @(posedge clk_i);
        resp_done_o <= 1'b1;
        @(posedge clk_i);
        resp_done_o <= 1'b0;
    endtask
endmodule

// >>> thermal_alarm_status_mask_bench.sv
module thermal_alarm_status_mask_bench
    import thermal_alarm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                ref_clk;
    logic                resetn;
    logic [NUM_CH-1:0]   conv_done;
    logic [NUM_CH*8-1:0] temp;
    logic [NUM_CH*8-1:0] high_lim;
    logic [NUM_CH*8-1:0] low_lim;
    logic [NUM_CH*8-1:0] ot_lim;
    logic [NUM_CH-1:0]   ot_wr;
    logic [NUM_CH-1:0]   fault;
    logic [7:0]          addr;
    logic                wr;
    logic                rd;
    logic                rd_d = 1'b0;
    logic [7:0]          wdata;
    logic                resp_done;
    logic [7:0]          rdata;
    logic                alert_n;
    logic                alert_oe;
    logic                overt_n;
    logic                overt_oe;
    logic [7:0]          expq[$];
    logic [7:0]          r;
    int                  fail_count = 0;
    int                  samples_checked = 0;
    int                  cycles = 0;
    int                  seed;

    thermal_alarm_status_mask u_dut (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .conv_done_i(conv_done), .temp_i(temp),
        .high_limit_i(high_lim), .low_limit_i(low_lim), .ot_limit_i(ot_lim),
        .ot_limit_wr_i(ot_wr), .sensor_fault_i(fault), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .alert_resp_done_i(resp_done),
        .reg_rdata_o(rdata), .alert_n_o(alert_n), .alert_oe_o(alert_oe),
        .overt_n_o(overt_n), .overt_oe_o(overt_oe));

    smbus_host_model u_host (
        .clk_i(ref_clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
        .resp_done_o(resp_done));

    //////////////////////////////////////////////////////////////
    // Clock, timeout and read-data monitor
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        rd_d <= rd;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end

    // Oldest expectation meets the data of each completed read
    always @(negedge ref_clk) begin
        if (rd_d === 1'b1) begin
            if (expq.size() == 0) begin
                fail_count++;
                $display("mismatch at %0t: unexpected read", $time);
            end else begin
                check(rdata, expq.pop_front());
            end
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic pins(input logic a, input logic o);
        #1;
        check({4'h0, alert_oe, alert_n, overt_oe, overt_n}, {4'h0, a, !a, o, !o});
    endtask

    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        u_host.xfer(a, 8'h00, 1'b0);
    endtask

    // Conversion end on channel c with result t and sensor state f
    task automatic conv(input int c, input logic [7:0] t, input logic f);
        @(posedge ref_clk);
        temp[c*8 +: 8] <= t;
        fault[c]       <= f;
        conv_done      <= 8'h01 << c;
        @(posedge ref_clk);
        conv_done      <= 8'h00;
    endtask

    function automatic logic [7:0] abit(input int c);
        return 8'h01 << ((c == 0) ? 6 : ((c == 7) ? 7 : c - 1));
    endfunction

    function automatic logic [7:0] obit(input int c);
        return 8'h01 << ((c == 0) ? 7 : c - 1);
    endfunction

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    //////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 32'h03C9F2E5;
        resetn = 1'b0;
        conv_done = 8'h00;
        temp = {NUM_CH{8'h32}};
        high_lim = {NUM_CH{8'h64}};
        low_lim = {NUM_CH{8'h0A}};
        ot_lim = {NUM_CH{8'h96}};
        ot_wr = 8'h00;
        fault = 8'h00;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        pins(1'b0, 1'b0);
        for (int a = 'h42; a <= 'h47; a++) rdx(8'(a), 8'h00);
        rdx(8'h50, 8'h00);
        r = 8'($random(seed));
        u_host.xfer(ADDR_ALERT_MASK, r, 1'b1);
        rdx(8'h42, r);
        u_host.xfer(ADDR_OT_MASK, ~r, 1'b1);
        rdx(8'h43, ~r);
        u_host.xfer(8'h45, 8'hFF, 1'b1);
        rdx(8'h45, 8'h00);
        u_host.xfer(ADDR_ALERT_MASK, 8'h00, 1'b1);
        u_host.xfer(ADDR_OT_MASK, 8'h00, 1'b1);
        $display("test reset and masks done");
        for (int c = 0; c < NUM_CH; c++) begin
            conv(c, 8'hC8, 1'b1);
            pins(1'b1, 1'b1);
            rdx(8'h44, abit(c));
            pins(1'b0, 1'b1);
            rdx(8'h44, 8'h00);
            rdx(8'h45, obit(c));
            rdx(8'h45, obit(c));
            rdx(8'h46, (c == 0) ? 8'h00 : 8'h01 << (c - 1));
            conv(c, 8'h92, 1'b1);
            pins(1'b1, 1'b1);
            rdx(8'h44, abit(c));
            conv(c, 8'h91, 1'b0);
            pins(1'b1, 1'b0);
            rdx(8'h45, 8'h00);
            rdx(8'h46, 8'h00);
            rdx(8'h44, abit(c));
            pins(1'b0, 1'b0);
        end
        $display("test channel sweep done");
        u_host.xfer(ADDR_ALERT_MASK, 8'h04, 1'b1);
        u_host.xfer(ADDR_OT_MASK, 8'h04, 1'b1);
        conv(3, 8'hC8, 1'b0);
        pins(1'b0, 1'b0);
        rdx(8'h44, 8'h04);
        u_host.xfer(ADDR_OT_MASK, 8'h00, 1'b1);
        @(posedge ref_clk);
        pins(1'b0, 1'b1);
        @(posedge ref_clk);
        ot_lim[3*8 +: 8] <= 8'hCC;
        ot_wr <= 8'h08;
        @(posedge ref_clk);
        ot_wr <= 8'h00;
        @(posedge ref_clk);
        pins(1'b0, 1'b0);
        rdx(8'h45, 8'h00);
        $display("test masking and limit rewrite done");
        conv(5, 8'h05, 1'b0);
        pins(1'b1, 1'b0);
        u_host.alert_resp();
        pins(1'b0, 1'b0);
        rdx(8'h47, abit(5));
        rdx(8'h47, 8'h00);
        @(posedge ref_clk);
        temp[2*8 +: 8] <= 8'hC8;
        conv(5, 8'h32, 1'b0);
        pins(1'b0, 1'b0);
        rdx(8'h44, 8'h00);
        repeat (3) @(posedge ref_clk);
        $display("test low flag and own channel done");
        results();
    end
endmodule
